// *** bench/field_pins.sv ***
/*
 * Model of the field side: sensors, keys and switches that drive the pins.
 * Assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps

module field_pins
    import preset_pkg::*;
(
    // Clock
    input  wire logic  CLK,
    // Pin levels
    output pins_t      pins
);
    import preset_pkg::*;

    initial
    begin
        pins = '0;
        pins.pwr = 1'b1;
    end

    task automatic set(input int k, input logic v);
        @(posedge CLK);
        pins[k] <= v;
    endtask

    // A pulse is held four cycles so the synchroniser sees it.
    // The quiet gap keeps the count spacing well above the minimum.
    task automatic pulse(input int k);
        set(k, 1'b1);
        repeat (3) @(posedge CLK);
        set(k, 1'b0);
        repeat (8) @(posedge CLK);
    endtask
endmodule

// *** bench/preset_batch_counter_output_tb.sv ***
/*
 * Self-checking bench of the preset counter with its batch count.
 * Assumes the shortened counts MS_TICK_CYCLES=4, COUNT_GAP_CYCLES=3, RESET_MIN_CYCLES=5.
 */
`timescale 1ns/1ps

module preset_batch_counter_output_tb;
    import preset_pkg::*;

    localparam int PA = 7, PRST = 5, PBRST = 4, PCOMP = 3, PGATE = 2, PKEY = 1, PPWR = 0;

    logic                clk, sys_rst, wr, rd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata, rdata, d;
    logic                control_output_first, control_output_second, bout;
    pins_t               pins;
    int                  n_mismatch, checked, p, c;
    int                  m_bpv, m_bset;
    bit                  m_bout;

    // ------------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    field_pins field_pins_i (.CLK(clk), .pins(pins));

    preset_counter #(.MS_TICK_CYCLES(4), .COUNT_GAP_CYCLES(3), .RESET_MIN_CYCLES(5))
    preset_counter_i (
        .CLK(clk), .SYS_RST(sys_rst),
        .COUNT_INPUT_A(pins.a), .COUNT_INPUT_B(pins.b), .RESET_IN(pins.rst),
        .BATCH_RESET_IN(pins.brst), .COMP_IN(pins.comp), .GATE_IN(pins.gate),
        .RESET_KEY(pins.key), .POWER_OK(pins.pwr),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CONTROL_OUTPUT_FIRST(control_output_first), .CONTROL_OUTPUT_SECOND(control_output_second), .BATCH_OUT(bout));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        if (a == OFS_BSET) m_bset = v;
    endtask

    task automatic rreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rreg(a, d);
        chk(d, e);
    endtask

    // One count that reaches the final preset, then the model's batch step.
    task automatic hit();
        field_pins_i.pulse(PA);
        if (pins.brst !== 1'b1) m_bpv = (m_bpv + 1) % 10000;
        if (m_bset != 0 && m_bpv >= m_bset) m_bout = 1;
    endtask

    task automatic chk_batch();
        repeat (3) @(posedge clk);
        chk_reg(OFS_BPV, m_bpv[15:0]);
        chk({15'h0, bout}, {15'h0, m_bout});
    endtask

    task automatic cycles(input int n);
        repeat (n)
        begin
            hit();
            field_pins_i.pulse(PKEY);
        end
        chk_batch();
    endtask

    initial
    begin
        #1000000;
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
        n_mismatch = 0; checked = 0; m_bpv = 0; m_bset = 0; m_bout = 0;
        c = $urandom(32'h24B6F855);
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        chk_reg(OFS_CTRL, 16'h0018);
        chk_reg(OFS_PULSE, 16'h03E8);
        chk_reg(OFS_PV, 16'h0000);
        chk_reg(OFS_BPV, 16'h0000);
        chk_reg(4'hF, 16'h0000);
        chk({13'h0, control_output_first, control_output_second, bout}, 16'h0000);
        wreg(OFS_PV, 16'h0005);
        chk_reg(OFS_PV, 16'h0000);
        p = 2 + $urandom % 3;
        wreg(OFS_PRESET1, p[15:0]);
        wreg(OFS_BSET, 16'h0002);
        for (int i = 1; i <= p; i++)
        begin
            field_pins_i.pulse(PA);
            chk_reg(OFS_PV, i[15:0]);
        end
        m_bpv = 1;
        chk({14'h0, control_output_first, control_output_second}, 16'h0003);
        chk_batch();
        field_pins_i.pulse(PKEY);
        chk_reg(OFS_PV, 16'h0000);
        chk({14'h0, control_output_first, control_output_second}, 16'h0000);
        chk_batch();
        wreg(OFS_PRESET1, 16'h0001);
        cycles(1);
        wreg(OFS_BSET, 16'h0005);
        chk_batch();
        hit();
        field_pins_i.set(PRST, 1'b1);
        repeat (8) @(posedge clk);
        field_pins_i.pulse(PA);
        field_pins_i.set(PRST, 1'b0);
        repeat (6) @(posedge clk);
        chk_reg(OFS_PV, 16'h0000);
        chk_batch();
        field_pins_i.set(PPWR, 1'b0);
        repeat (8) @(posedge clk);
        chk({15'h0, bout}, 16'h0000);
        field_pins_i.set(PPWR, 1'b1);
        chk_batch();
        field_pins_i.set(PBRST, 1'b1);
        m_bpv = 0; m_bout = 0;
        hit();
        field_pins_i.set(PBRST, 1'b0);
        chk_batch();
        field_pins_i.pulse(PKEY);
        cycles(2);
        wreg(OFS_BSET, 16'h0001);
        m_bout = 1;
        chk_batch();
        field_pins_i.pulse(PBRST);
        m_bpv = 0; m_bout = 0;
        wreg(OFS_BSET, 16'h0000);
        cycles(2);
        field_pins_i.set(PGATE, 1'b1);
        field_pins_i.pulse(PA);
        field_pins_i.set(PGATE, 1'b0);
        chk_reg(OFS_PV, 16'h0000);
        c = 1 + $urandom % 7;
        wreg(OFS_PRESET1, 16'h0009);
        wreg(OFS_COMP, c[15:0]);
        field_pins_i.set(PCOMP, 1'b1);
        field_pins_i.pulse(PA);
        chk_reg(OFS_PV, c[15:0]);
        wreg(OFS_CTRL, 16'h001A);
        field_pins_i.pulse(PKEY);
        field_pins_i.pulse(PA);
        chk_reg(OFS_PV, 16'h0008);
        wreg(OFS_CTRL, 16'h0038);
        field_pins_i.pulse(PKEY);
        repeat (4) @(posedge clk);
        chk({15'h0, control_output_first}, 16'h0001);
        wreg(OFS_CTRL, 16'h0010);
        wreg(OFS_PULSE, 16'h000A);
        // Compensation is still held, so the up count loads c; make c the preset.
        wreg(OFS_PRESET1, c[15:0]);
        hit();
        repeat (20) @(posedge clk);
        chk({14'h0, control_output_first, control_output_second}, 16'h0003);
        repeat (30) @(posedge clk);
        chk({14'h0, control_output_first, control_output_second}, 16'h0001);
        field_pins_i.set(PCOMP, 1'b0);
        chk_batch();
        stop_test();
    end
endmodule

// *** hdl/preset_counter.sv ***
/*
 * Preset counter core: count inputs, two presets, two control outputs
 * (held or one-shot, selectable polarity) and a 4-digit batch counter.
 * Assumes all pin inputs are asynchronous and that settings persist while
 * POWER_OK is low, as a backup supply would keep them.
 */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Operation
// - Batch count steps when the final stage preset is reached.
// - Batch reset held forces batch value to zero.
// - Batch setpoint zero: batch counts, batch output never asserts.
// - Batch value past 9999 wraps to zero.
// - Reset key and reset input leave batch value and output alone.
// - Batch output asserted before power loss is asserted again after.
// - Lowering batch setpoint below batch value asserts output at once.
// - Raising batch setpoint afterwards does not drop the batch output.
// - One-shot duration programmable from 10 ms to 1000 ms.
// - Compensation during a one-shot pulse does not shorten it.
// - Preset reached again during a one-shot restarts its full interval.
// - Compensation acts only on up counts.
// - Per-output polarity bit selects off-to-on or on-to-off action.
// - Polarity bits reset to off-to-on.
// - Second output mode only on one-stage; two-stage uses preset two.
// - Reset key zeroes present value (loads the preset in down mode) and clears control outputs.
// - Counts limited to 30 per second; reset needs 20 ms width.
// - Power-up defaults: zero values, no output asserted.
// - Settings and values kept across external supply loss.
// - Batch output stays until batch reset becomes active.
// - Counts during main reset are discarded.
// - Gate input freezes the present value.
// - Up edge with compensation loads the compensation value.
module preset_counter #(
    parameter int unsigned MS_TICK_CYCLES   = preset_pkg::MS_TICK_CYC,
    parameter int unsigned COUNT_GAP_CYCLES = preset_pkg::COUNT_GAP_CYC,
    parameter int unsigned RESET_MIN_CYCLES = preset_pkg::RESET_MIN_CYC
) (
    // Clock and reset
    input  wire logic                            CLK,
    input  wire logic                            SYS_RST,
    // Field inputs
    input  wire logic                            COUNT_INPUT_A,
    input  wire logic                            COUNT_INPUT_B,
    input  wire logic                            RESET_IN,
    input  wire logic                            BATCH_RESET_IN,
    input  wire logic                            COMP_IN,
    input  wire logic                            GATE_IN,
    input  wire logic                            RESET_KEY,
    input  wire logic                            POWER_OK,
    // Register port
    input  wire logic [preset_pkg::ADDR_W-1:0]   ADDR,
    input  wire logic [preset_pkg::DATA_W-1:0]   WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output logic      [preset_pkg::DATA_W-1:0]   RDATA,
    // Outputs
    output logic                                 CONTROL_OUTPUT_FIRST,
    output logic                                 CONTROL_OUTPUT_SECOND,
    output logic                                 BATCH_OUT
);
    import preset_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic pin_level(input logic pwr, input logic act, input logic pol);
        pin_level = pwr & (act ^ pol);
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    pins_t s1_q;
    pins_t s2_q;
    pins_t s3_q;
    pins_t pins;
    pins_t rise;

    assign pins = '{a: COUNT_INPUT_A, b: COUNT_INPUT_B, rst: RESET_IN, brst: BATCH_RESET_IN,
                    comp: COMP_IN, gate: GATE_IN, key: RESET_KEY, pwr: POWER_OK};
    assign rise = s2_q & ~s3_q;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers and counting state
    // ------------------------------------------------------------------
    cfg_t                cfg_q, cfg_d;
    logic [DATA_W-1:0]   preset1_q, preset1_d;
    logic [DATA_W-1:0]   preset2_q, preset2_d;
    logic [DATA_W-1:0]   comp_q, comp_d;
    logic [DATA_W-1:0]   pulse_q, pulse_d;
    logic [DATA_W-1:0]   bset_q, bset_d;
    logic [DATA_W-1:0]   pv_q, pv_d;
    logic [DATA_W-1:0]   bpv_q, bpv_d;
    logic                bout_q, bout_d;
    logic [1:0]          act_q, act_d;
    logic [TMR_W-1:0]    tmr_q [2];
    logic [TMR_W-1:0]    tmr_d [2];
    logic [CNT_W-1:0]    tick_q, tick_d;
    logic [CNT_W-1:0]    gap_q, gap_d;
    logic [CNT_W-1:0]    rcnt_q, rcnt_d;
    rst_state_t          rs_q, rs_d;
    logic [DATA_W-1:0]   rdata_d;
    logic                control_output_first_d, control_output_second_d;

    logic                tick;
    logic                ext_fire;
    logic                clr;
    logic                up_ev, dn_ev, accept;
    logic [DATA_W-1:0]   pv_n;
    logic                match1, match2, final_match;
    logic [1:0]          src;
    logic [1:0]          hold;

    always_comb
    begin
        cfg_d     = cfg_q;
        preset1_d = preset1_q;
        preset2_d = preset2_q;
        comp_d    = comp_q;
        pulse_d   = pulse_q;
        bset_d    = bset_q;
        rdata_d   = ZERO_W;

        // Millisecond tick for the one-shot timers.
        tick   = (tick_q == CNT_W'(MS_TICK_CYCLES - 1));
        tick_d = tick ? '0 : tick_q + CNT_ONE;

        // Reset input must stay high for its minimum width to be taken.
        rs_d     = rs_q;
        rcnt_d   = rcnt_q;
        ext_fire = 1'b0;
        case (rs_q)
            RS_IDLE:
            begin
                rcnt_d = CNT_ONE;
                if (s2_q.rst && s2_q.pwr)
                    rs_d = RS_WAIT;
            end
            RS_WAIT:
            begin
                if (!s2_q.rst)
                    rs_d = RS_IDLE;
                else if (rcnt_q == CNT_W'(RESET_MIN_CYCLES - 1))
                begin
                    ext_fire = 1'b1;
                    rs_d     = RS_DONE;
                end
                else
                    rcnt_d = rcnt_q + CNT_ONE;
            end
            RS_DONE:
            begin
                if (!s2_q.rst)
                    rs_d = RS_IDLE;
            end
            default:
                rs_d = RS_IDLE;
        endcase
        clr = ext_fire | (rise.key & s2_q.pwr);

        // Count decoding and acceptance.
        up_ev = 1'b0;
        dn_ev = 1'b0;
        case (cfg_q.in_mode)
            IN_UP:     up_ev = rise.a;
            IN_DOWN:   dn_ev = rise.a;
            IN_UPDOWN:
            begin
                up_ev = rise.a & ~rise.b;
                dn_ev = rise.b & ~rise.a;
            end
            default:   up_ev = 1'b0;
        endcase
        accept = (up_ev | dn_ev) && (gap_q == '0) && !s2_q.rst
                 && !s2_q.gate && s2_q.pwr;
        if (accept)
            gap_d = CNT_W'(COUNT_GAP_CYCLES - 1);
        else if (gap_q != '0)
            gap_d = gap_q - CNT_ONE;
        else
            gap_d = gap_q;

        if (up_ev && s2_q.comp)
            pv_n = comp_q;
        else if (up_ev)
            pv_n = pv_q + ONE_W;
        else
            pv_n = pv_q - ONE_W;

        match1      = accept && (pv_n == preset1_q);
        match2      = accept && (pv_n == preset2_q);
        final_match = cfg_q.two_stage ? match2 : match1;
        src[0]      = match1;
        src[1]      = cfg_q.two_stage ? match2 : match1;
        hold        = {cfg_q.hold2, cfg_q.hold1};

        if (clr)
            pv_d = (cfg_q.in_mode == IN_DOWN)
                   ? (cfg_q.two_stage ? preset2_q : preset1_q) : ZERO_W;
        else if (accept)
            pv_d = pv_n;
        else
            pv_d = pv_q;

        // Control outputs, held or one-shot.
        for (int i = 0; i < 2; i++)
        begin
            act_d[i] = act_q[i];
            tmr_d[i] = tmr_q[i];
            if (clr)
            begin
                act_d[i] = 1'b0;
                tmr_d[i] = '0;
            end
            else if (src[i])
            begin
                act_d[i] = 1'b1;
                tmr_d[i] = TMR_W'(pulse_q);
            end
            else if (act_q[i] && !hold[i] && tick)
            begin
                tmr_d[i] = tmr_q[i] - TMR_ONE;
                if (tmr_q[i] <= TMR_ONE)
                    act_d[i] = 1'b0;
            end
        end

        // Batch counter; untouched by the main reset paths.
        bpv_d  = bpv_q;
        bout_d = bout_q;
        if (s2_q.pwr)
        begin
            if (s2_q.brst)
            begin
                bpv_d = ZERO_W;
                if (rise.brst)
                    bout_d = 1'b0;
            end
            else
            begin
                if (final_match)
                    bpv_d = (bpv_q == BATCH_MAX) ? ZERO_W : bpv_q + ONE_W;
                if (bset_q != ZERO_W && bpv_q >= bset_q)
                    bout_d = 1'b1;
            end
        end

        // Register port.
        if (WR)
        begin
            case (ADDR)
                OFS_CTRL:    cfg_d     = cfg_t'(WDATA[CFG_W-1:0]);
                OFS_PRESET1: preset1_d = WDATA;
                OFS_PRESET2: preset2_d = WDATA;
                OFS_COMP:    comp_d    = WDATA;
                OFS_PULSE:   pulse_d   = (WDATA < PULSE_MIN) ? PULSE_MIN
                                       : (WDATA > PULSE_MAX) ? PULSE_MAX : WDATA;
                OFS_BSET:    bset_d    = WDATA;
                default:     cfg_d     = cfg_q;
            endcase
        end
        if (RD)
        begin
            case (ADDR)
                OFS_CTRL:    rdata_d = {{(DATA_W-CFG_W){1'b0}}, cfg_q};
                OFS_PRESET1: rdata_d = preset1_q;
                OFS_PRESET2: rdata_d = preset2_q;
                OFS_COMP:    rdata_d = comp_q;
                OFS_PULSE:   rdata_d = pulse_q;
                OFS_BSET:    rdata_d = bset_q;
                OFS_PV:      rdata_d = pv_q;
                OFS_BPV:     rdata_d = bpv_q;
                OFS_STAT:    rdata_d = {11'h000, s2_q.gate, s2_q.rst, bout_q, act_q};
                default:     rdata_d = ZERO_W;
            endcase
        end

        control_output_first_d = pin_level(s2_q.pwr, act_q[0], cfg_q.pol1);
        control_output_second_d = pin_level(s2_q.pwr, act_q[1], cfg_q.pol2);
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            cfg_q                 <= CFG_RST;
            preset1_q             <= ZERO_W;
            preset2_q             <= ZERO_W;
            comp_q                <= ZERO_W;
            pulse_q               <= PULSE_RST;
            bset_q                <= ZERO_W;
            pv_q                  <= ZERO_W;
            bpv_q                 <= ZERO_W;
            bout_q                <= 1'b0;
            act_q                 <= 2'b00;
            tmr_q[0]              <= '0;
            tmr_q[1]              <= '0;
            tick_q                <= '0;
            gap_q                 <= '0;
            rcnt_q                <= '0;
            rs_q                  <= RS_IDLE;
            RDATA                 <= ZERO_W;
            CONTROL_OUTPUT_FIRST  <= 1'b0;
            CONTROL_OUTPUT_SECOND <= 1'b0;
            BATCH_OUT             <= 1'b0;
        end
        else
        begin
            cfg_q                 <= cfg_d;
            preset1_q             <= preset1_d;
            preset2_q             <= preset2_d;
            comp_q                <= comp_d;
            pulse_q               <= pulse_d;
            bset_q                <= bset_d;
            pv_q                  <= pv_d;
            bpv_q                 <= bpv_d;
            bout_q                <= bout_d;
            act_q                 <= act_d;
            tmr_q[0]              <= tmr_d[0];
            tmr_q[1]              <= tmr_d[1];
            tick_q                <= tick_d;
            gap_q                 <= gap_d;
            rcnt_q                <= rcnt_d;
            rs_q                  <= rs_d;
            RDATA                 <= rdata_d;
            CONTROL_OUTPUT_FIRST  <= control_output_first_d;
            CONTROL_OUTPUT_SECOND <= control_output_second_d;
            BATCH_OUT             <= s2_q.pwr & bout_q;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_batch_wrap_zero: assert property (final_match && bpv_q == BATCH_MAX && !s2_q.brst
        |=> bpv_q == ZERO_W) else $error("batch value did not wrap");
    a_batch_reset_hold: assert property (s2_q.brst && s2_q.pwr |=> bpv_q == ZERO_W)
        else $error("batch value not zero under batch reset");
    a_batch_zero_set: assert property ($rose(bout_q) |-> $past(bset_q) != ZERO_W)
        else $error("batch output set with zero setpoint");
    a_batch_out_sticky: assert property (bout_q && !(rise.brst && s2_q.pwr) |=> bout_q)
        else $error("batch output dropped without batch reset");
    a_reset_keeps_batch: assert property (clr && !s2_q.brst && !final_match
        |=> $stable(bpv_q) && (bout_q || !$past(bout_q))) else $error("reset touched batch");
    a_gate_freezes_pv: assert property (s2_q.gate && !clr |=> $stable(pv_q))
        else $error("present value moved while gated");
    a_reset_discards: assert property (s2_q.rst && !clr |=> $stable(pv_q))
        else $error("count taken during reset");
    a_comp_loads_pv: assert property (accept && up_ev && s2_q.comp && !clr
        |=> pv_q == $past(comp_q)) else $error("compensation value not loaded");
    a_oneshot_restart: assert property (src[0] && !clr |=> act_q[0]
        && tmr_q[0] == TMR_W'($past(pulse_q))) else $error("one-shot not restarted");
    a_pulse_in_range: assert property (pulse_q >= PULSE_MIN && pulse_q <= PULSE_MAX)
        else $error("pulse time out of range");
    a_clear_outputs: assert property (clr |=> act_q == 2'b00 ##1
        !CONTROL_OUTPUT_FIRST || cfg_q.pol1) else $error("clear left output active");

    c_batch_out: cover property (!bout_q ##1 bout_q);
    c_batch_wrap: cover property (final_match && bpv_q == BATCH_MAX);
    c_oneshot_end: cover property (act_q[0] && !hold[0] ##1 !act_q[0]);
    c_comp_load: cover property (accept && up_ev && s2_q.comp);

endmodule

// *** hdl/preset_pkg.sv ***
/*
 * Shared constants and types of the preset counter with batch count.
 * Assumes a single 20 MHz system clock and a word register port of 16 bits.
 */
package preset_pkg;

    // ------------------------------------------------------------------
    // Bus and widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 20;
    localparam int unsigned TMR_W  = 10;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PRESET1 = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PRESET2 = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_COMP    = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PULSE   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_BSET    = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_PV      = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_BPV     = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_STAT    = 4'h8;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned MS_TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned COUNT_CPS     = 30;
    localparam int unsigned COUNT_GAP_CYC = (CLK_HZ + COUNT_CPS - 1) / COUNT_CPS;
    localparam int unsigned RESET_MIN_MS  = 20;
    localparam int unsigned RESET_MIN_CYC = CLK_HZ / 1000 * RESET_MIN_MS;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] ZERO_W     = 16'h0000;
    localparam logic [DATA_W-1:0] ONE_W      = 16'h0001;
    localparam logic [DATA_W-1:0] BATCH_MAX  = 16'h270F;
    localparam logic [DATA_W-1:0] PULSE_MIN  = 16'h000A;
    localparam logic [DATA_W-1:0] PULSE_MAX  = 16'h03E8;
    localparam logic [DATA_W-1:0] PULSE_RST  = 16'h03E8;
    localparam logic [TMR_W-1:0]  TMR_ONE    = 10'h001;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 20'h00001;

    typedef enum logic [1:0] {IN_UP, IN_DOWN, IN_UPDOWN} in_mode_t;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_DONE} rst_state_t;

    typedef struct packed {
        logic     pol2;
        logic     pol1;
        logic     hold2;
        logic     hold1;
        in_mode_t in_mode;
        logic     two_stage;
    } cfg_t;

    localparam int unsigned CFG_W = 7;
    localparam cfg_t CFG_RST = '{pol2: 1'b0, pol1: 1'b0, hold2: 1'b1, hold1: 1'b1,
                                 in_mode: IN_UP, two_stage: 1'b0};

    typedef struct packed {
        logic a;
        logic b;
        logic rst;
        logic brst;
        logic comp;
        logic gate;
        logic key;
        logic pwr;
    } pins_t;

endpackage
